/* File: core/uafs_pkg.sv */
/*
 * Shared constants and types of the serial core: register offsets,
 * configuration layouts, reset values, state enumerations and counts.
 * Assumes a 32-bit plain register port with byte offsets as addresses.
 */
package uafs_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] DATA_OFS = 8'h00;
   localparam logic [7:0] FLAG_OFS = 8'h04;
   localparam logic [7:0] LINE_OFS = 8'h08;
   localparam logic [7:0] CTRL_OFS = 8'h0C;
   localparam logic [7:0] DIVI_OFS = 8'h10;
   localparam logic [7:0] DIVF_OFS = 8'h14;
   localparam logic [7:0] XCHR_OFS = 8'h18;

   // ************************************************************
   // Field layouts, low bits of each register
   // ************************************************************
   typedef struct packed {
      logic sw_fc_en;
      logic cts_en;
      logic rts_en;
      logic rx_en;
      logic tx_en;
      logic half_oversample_sel;
      logic uart_en;
   } uafs_ctrl_t;

   typedef struct packed {
      logic stick;
      logic fifo_en;
      logic [1:0] wlen;
      logic two_stop;
      logic even;
      logic par_en;
      logic brk;
   } uafs_line_t;

   typedef struct packed {
      logic tx_empty;
      logic rx_full;
      logic tx_full;
      logic rx_empty;
      logic busy;
      logic ovr_pend;
      logic xoff_held;
      logic cts;
   } uafs_flag_t;

   // Receive entry: overrun, break, parity, framing, data
   typedef struct packed {
      logic ovr;
      logic brk;
      logic perr;
      logic ferr;
      logic [7:0] data;
   } uafs_rx_entry_t;

   // ************************************************************
   // Reset values and counts
   // ************************************************************
   localparam uafs_ctrl_t CTRL_RESET = 7'h0C;
   localparam uafs_line_t LINE_RESET = 8'h50;
   localparam logic [7:0] XON_RESET = 8'h11;
   localparam logic [7:0] XOFF_RESET = 8'h13;
   localparam logic [3:0] MIN_BITS = 4'h5;
   localparam logic [4:0] OSR_FULL = 5'h10;
   localparam logic [4:0] OSR_HALF = 5'h08;
   localparam logic [4:0] START_FULL = 5'h08;
   localparam logic [4:0] START_HALF = 5'h04;
   localparam int DIV_INT_W = 16;
   localparam int DIV_FRAC_W = 6;

   // ************************************************************
   // State machines
   // ************************************************************
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uafs_tx_st_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK, RX_WAIT}
      uafs_rx_st_t;

endpackage

/* File: core/uafs_fifo.sv */
/*
 * Queue of flip-flops with count, full and empty; a single mode shows
 * it as a one-entry holding register by its flags alone.
 * Assumes DEPTH is a power of two so that the pointers wrap freely.
 */
module uafs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 64
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic single,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata,
   output logic empty,
   output logic full,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } uafs_fifo_st_t;

   uafs_fifo_st_t s;
   uafs_fifo_st_t next_s;
   logic do_push;
   logic do_pop;

   assign empty = (s.cnt == '0);
   assign full = single ? !empty : (s.cnt == CW'(DEPTH));
   assign count = s.cnt;
   assign rdata = s.mem[s.rp];
   assign do_push = push && !full;
   assign do_pop = pop && !empty;

   always_comb
   begin
      next_s = s;
      if (do_push)
      begin
         next_s.mem[s.wp] = wdata;
         next_s.wp = s.wp + AW'(1);
      end
      if (do_pop)
      begin
         next_s.rp = s.rp + AW'(1);
      end
      if (do_push && !do_pop)
      begin
         next_s.cnt = s.cnt + CW'(1);
      end
      else if (do_pop && !do_push)
      begin
         next_s.cnt = s.cnt - CW'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         s <= '0;
      else if (ce)
         s <= next_s;
   end
endmodule

/* File: core/uafs_baud.sv */
/*
 * Fractional divider making the oversampling enable pulse.
 * Assumes the divisor is held steady while the core is enabled.
 */
module uafs_baud (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic en,
   input wire logic [uafs_pkg::DIV_INT_W-1:0] divisor_integer,
   input wire logic [uafs_pkg::DIV_FRAC_W-1:0] divisor_fraction,
   output logic oversample_pulse
);
   typedef struct packed {
      logic [uafs_pkg::DIV_INT_W:0] cnt;
      logic [uafs_pkg::DIV_FRAC_W-1:0] acc;
      logic pulse;
   } uafs_baud_st_t;

   uafs_baud_st_t s;
   uafs_baud_st_t next_s;
   logic [uafs_pkg::DIV_FRAC_W:0] sum;
   logic [uafs_pkg::DIV_INT_W:0] period;

   assign oversample_pulse = s.pulse;

   always_comb
   begin
      next_s = s;
      next_s.pulse = 1'b0;
      sum = {1'b0, s.acc} + {1'b0, divisor_fraction};
      period = {1'b0, divisor_integer} + {{uafs_pkg::DIV_INT_W{1'b0}}, sum[uafs_pkg::DIV_FRAC_W]};
      // Integer period, one clock longer on each fraction carry
      if (!en || divisor_integer == '0)
      begin
         next_s.cnt = {{uafs_pkg::DIV_INT_W{1'b0}}, 1'b1};
         next_s.acc = '0;
      end
      else if (s.cnt >= period)
      begin
         next_s.pulse = 1'b1;
         next_s.cnt = {{uafs_pkg::DIV_INT_W{1'b0}}, 1'b1};
         next_s.acc = sum[uafs_pkg::DIV_FRAC_W-1:0];
      end
      else
      begin
         next_s.cnt = s.cnt + {{uafs_pkg::DIV_INT_W{1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         s <= '0;
      else if (ce)
         s <= next_s;
   end
endmodule

/* File: core/uafs_core.sv */
/*
 * Serial transmitter and receiver with transmit and receive queues,
 * registers on a plain strobe port, hardware and software flow control.
 * Assumes rx_in and cts_n are already synchronous to clk.
 */
// Functional notes
// - Character length is five to eight bits; both ends must match.
// - Parity generated and checked: even, odd, stick, or none.
// - Transmitter appends one or two stop bits.
// - Transmit queue 8x64, receive queue 12x64.
// - Receive entry: data 7:0, framing 8, parity 9, break 10, overrun 11.
// - Full receive queue: character dropped, overrun state set.
// - Next stored character carries pending overrun, which then clears.
// - Enabled transmitter sends while the transmit queue holds data.
// - Busy set once a byte enters the transmit queue, held while sending.
// - Busy clears when queue empty and last stop bit has left.
// - Busy follows activity even with the UART disabled.
// - Each data, parity and stop bit is a majority of three samples around mid-bit; the start recheck takes one sample.
// - Start rechecked on eighth pulse, fourth in half mode; high line means false start.
// - Data bits sampled every sixteen pulses, eight in half mode, after a valid start.
// - Parity bit checked after data; mismatch flags parity error.
// - Stop bit must sample high, else framing error.
// - Each completed character stored with its error flags unless the receive queue is full.
// - Break generated on transmit and detected on receive.
// - Queues disabled: one-byte holding registers via flag handling.
// - Queues disabled: overrun when a character arrives while one is unread; the new one is dropped.
// - CTS/RTS hardware and Xon/Xoff software flow control.
// - Divisor is 16 integer plus 6 fraction bits.
// - Oversample pulse averages 16x, or 8x in half mode.
module uafs_core #(
   parameter int TX_DEPTH = 64,
   parameter int RX_DEPTH = 64,
   parameter int RX_WATERMARK = 32
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic rx_in,
   input wire logic cts_n,
   output logic tx_out,
   output logic rts_n
);
   localparam int RCW = $clog2(RX_DEPTH+1);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      uafs_pkg::uafs_ctrl_t ctrl;
      uafs_pkg::uafs_line_t tx_line_control;
      logic [15:0] divisor_integer;
      logic [5:0] divisor_fraction;
      logic [7:0] xon_char;
      logic [7:0] xoff_char;
      logic [31:0] rdata;
      uafs_pkg::uafs_tx_st_t tx_st;
      logic [7:0] tx_shift;
      logic tx_par;
      logic [2:0] tx_bit;
      logic [4:0] tx_tick;
      logic tx_line;
      logic tx_out;
      logic rts_n;
      uafs_pkg::uafs_rx_st_t rx_st;
      logic rx_prev;
      logic [2:0] rx_hist;
      logic [7:0] rx_shift;
      logic [2:0] rx_bit;
      logic [4:0] rx_tick;
      logic rx_perr;
      logic [7:0] low_cnt;
      logic ovr_pend;
      logic xoff_held;
   } uafs_core_st_t;

   localparam uafs_core_st_t RESET_ST = '{
      ctrl: uafs_pkg::CTRL_RESET,
      tx_line_control: uafs_pkg::LINE_RESET,
      xon_char: uafs_pkg::XON_RESET,
      xoff_char: uafs_pkg::XOFF_RESET,
      tx_st: uafs_pkg::TX_IDLE,
      rx_st: uafs_pkg::RX_IDLE,
      tx_line: 1'b1,
      tx_out: 1'b1,
      rx_prev: 1'b1,
      rx_hist: 3'h7,
      default: '0
   };

   uafs_core_st_t s;
   uafs_core_st_t next_s;

   logic oversample_pulse;
   logic tx_push;
   logic tx_pop;
   logic tx_empty;
   logic tx_full;
   logic [7:0] tx_head;
   logic rx_push;
   logic rx_pop;
   logic rx_empty;
   logic rx_full;
   uafs_pkg::uafs_rx_entry_t rx_head;
   uafs_pkg::uafs_rx_entry_t rx_entry;
   logic [RCW-1:0] rx_count;

   // ************************************************************
   // Submodules
   // ************************************************************
   uafs_baud u_baud (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .en(s.ctrl.uart_en),
      .divisor_integer(s.divisor_integer),
      .divisor_fraction(s.divisor_fraction),
      .oversample_pulse(oversample_pulse)
   );

   uafs_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .single(!s.tx_line_control.fifo_en),
      .push(tx_push),
      .pop(tx_pop),
      .wdata(wdata[7:0]),
      .rdata(tx_head),
      .empty(tx_empty),
      .full(tx_full),
      .count()
   );

   uafs_fifo #(.WIDTH(12), .DEPTH(RX_DEPTH)) u_rx_fifo (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .single(!s.tx_line_control.fifo_en),
      .push(rx_push),
      .pop(rx_pop),
      .wdata(rx_entry),
      .rdata(rx_head),
      .empty(rx_empty),
      .full(rx_full),
      .count(rx_count)
   );

   assign rdata = s.rdata;
   assign tx_out = s.tx_out;
   assign rts_n = s.rts_n;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic par_of(input logic [7:0] d, input logic [3:0] nb,
                                   input uafs_pkg::uafs_line_t ln);
      logic [7:0] m;
      m = 8'hFF >> (4'h8 - nb);
      if (ln.stick)
         par_of = !ln.even;
      else
         par_of = ln.even ? ^(d & m) : !(^(d & m));
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   logic [3:0] nbits;
   logic [4:0] osr;
   logic [4:0] start_pt;
   logic tx_go;
   logic tick_end;
   logic [2:0] v;
   logic vote;
   logic [7:0] rx_data;
   logic do_store;
   logic st_perr;
   logic st_ferr;
   logic st_brk;
   logic [3:0] frame_bits;
   logic [7:0] frame_p;
   uafs_pkg::uafs_flag_t flags;

   always_comb
   begin
      next_s = s;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      rx_pop = 1'b0;
      rx_push = 1'b0;
      rx_entry = '0;
      do_store = 1'b0;
      st_perr = 1'b0;
      st_ferr = 1'b0;
      st_brk = 1'b0;
      nbits = uafs_pkg::MIN_BITS + {2'h0, s.tx_line_control.wlen};
      osr = s.ctrl.half_oversample_sel ? uafs_pkg::OSR_HALF : uafs_pkg::OSR_FULL;
      start_pt = s.ctrl.half_oversample_sel ? uafs_pkg::START_HALF : uafs_pkg::START_FULL;
      frame_bits = 4'h2 + nbits + {3'h0, s.tx_line_control.par_en}
                   + {3'h0, s.tx_line_control.two_stop};
      frame_p = s.ctrl.half_oversample_sel ? {1'b0, frame_bits, 3'h0} : {frame_bits, 4'h0};
      v = {s.rx_hist[1:0], rx_in};
      vote = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
      rx_data = s.rx_shift >> (4'h8 - nbits);
      flags.tx_empty = tx_empty;
      flags.rx_full = rx_full;
      flags.tx_full = tx_full;
      flags.rx_empty = rx_empty;
      flags.busy = !tx_empty || (s.tx_st != uafs_pkg::TX_IDLE);
      flags.ovr_pend = s.ovr_pend;
      flags.xoff_held = s.xoff_held;
      flags.cts = !cts_n;

      // Register writes
      if (wr)
      begin
         if (addr == uafs_pkg::DATA_OFS)
            tx_push = 1'b1;
         else if (addr == uafs_pkg::LINE_OFS)
            next_s.tx_line_control = wdata[7:0];
         else if (addr == uafs_pkg::CTRL_OFS)
            next_s.ctrl = wdata[6:0];
         else if (addr == uafs_pkg::DIVI_OFS)
            next_s.divisor_integer = wdata[15:0];
         else if (addr == uafs_pkg::DIVF_OFS)
            next_s.divisor_fraction = wdata[5:0];
         else if (addr == uafs_pkg::XCHR_OFS)
         begin
            next_s.xon_char = wdata[7:0];
            next_s.xoff_char = wdata[15:8];
         end
      end

      // Register reads, data valid for one cycle only
      next_s.rdata = '0;
      if (rd)
      begin
         if (addr == uafs_pkg::DATA_OFS)
         begin
            rx_pop = !rx_empty;
            next_s.rdata = rx_empty ? 32'h0 : {20'h0, rx_head};
         end
         else if (addr == uafs_pkg::FLAG_OFS)
            next_s.rdata = {24'h0, flags};
         else if (addr == uafs_pkg::LINE_OFS)
            next_s.rdata = {24'h0, s.tx_line_control};
         else if (addr == uafs_pkg::CTRL_OFS)
            next_s.rdata = {25'h0, s.ctrl};
         else if (addr == uafs_pkg::DIVI_OFS)
            next_s.rdata = {16'h0, s.divisor_integer};
         else if (addr == uafs_pkg::DIVF_OFS)
            next_s.rdata = {26'h0, s.divisor_fraction};
         else if (addr == uafs_pkg::XCHR_OFS)
            next_s.rdata = {16'h0, s.xoff_char, s.xon_char};
      end

      // ************************************************************
      // Transmitter
      // ************************************************************
      tx_go = s.ctrl.uart_en && s.ctrl.tx_en && !tx_empty
              && (!s.ctrl.cts_en || !cts_n) && !(s.ctrl.sw_fc_en && s.xoff_held);
      tick_end = oversample_pulse && (s.tx_tick == osr - 5'h1);
      if (oversample_pulse && !tick_end)
         next_s.tx_tick = s.tx_tick + 5'h1;
      case (s.tx_st)
         uafs_pkg::TX_IDLE:
         begin
            next_s.tx_line = 1'b1;
            if (tx_go)
            begin
               tx_pop = 1'b1;
               next_s.tx_shift = tx_head;
               next_s.tx_par = par_of(tx_head, nbits, s.tx_line_control);
               next_s.tx_tick = '0;
               next_s.tx_bit = '0;
               next_s.tx_line = 1'b0;
               next_s.tx_st = uafs_pkg::TX_START;
            end
         end
         uafs_pkg::TX_START:
         begin
            if (tick_end)
            begin
               next_s.tx_tick = '0;
               next_s.tx_line = s.tx_shift[0];
               next_s.tx_st = uafs_pkg::TX_DATA;
            end
         end
         uafs_pkg::TX_DATA:
         begin
            if (tick_end)
            begin
               next_s.tx_tick = '0;
               next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
               if (s.tx_bit == 3'(nbits - 4'h1))
               begin
                  next_s.tx_bit = '0;
                  next_s.tx_line = s.tx_line_control.par_en ? s.tx_par : 1'b1;
                  next_s.tx_st = s.tx_line_control.par_en ? uafs_pkg::TX_PAR : uafs_pkg::TX_STOP;
               end
               else
               begin
                  next_s.tx_bit = s.tx_bit + 3'h1;
                  next_s.tx_line = s.tx_shift[1];
               end
            end
         end
         uafs_pkg::TX_PAR:
         begin
            if (tick_end)
            begin
               next_s.tx_tick = '0;
               next_s.tx_line = 1'b1;
               next_s.tx_st = uafs_pkg::TX_STOP;
            end
         end
         uafs_pkg::TX_STOP:
         begin
            if (tick_end)
            begin
               next_s.tx_tick = '0;
               if (s.tx_line_control.two_stop && s.tx_bit == 3'h0)
                  next_s.tx_bit = 3'h1;
               else
                  next_s.tx_st = uafs_pkg::TX_IDLE;
            end
         end
         default: next_s.tx_st = uafs_pkg::TX_IDLE;
      endcase
      next_s.tx_out = next_s.tx_line && !next_s.tx_line_control.brk;

      // ************************************************************
      // Receiver
      // ************************************************************
      next_s.rx_prev = rx_in;
      if (oversample_pulse)
      begin
         next_s.rx_hist = v;
         next_s.rx_tick = s.rx_tick + 5'h1;
         if (rx_in)
            next_s.low_cnt = '0;
         else if (s.low_cnt != 8'hFF)
            next_s.low_cnt = s.low_cnt + 8'h1;
      end
      case (s.rx_st)
         uafs_pkg::RX_IDLE:
         begin
            if (s.ctrl.uart_en && s.ctrl.rx_en && s.rx_prev && !rx_in)
            begin
               next_s.rx_tick = '0;
               next_s.rx_bit = '0;
               next_s.rx_st = uafs_pkg::RX_START;
            end
         end
         uafs_pkg::RX_START:
         begin
            if (oversample_pulse && next_s.rx_tick == start_pt)
            begin
               next_s.rx_tick = '0;
               next_s.rx_st = rx_in ? uafs_pkg::RX_IDLE : uafs_pkg::RX_DATA;
            end
         end
         uafs_pkg::RX_DATA:
         begin
            if (oversample_pulse && next_s.rx_tick == osr + 5'h1)
            begin
               next_s.rx_tick = 5'h1;
               next_s.rx_shift = {vote, s.rx_shift[7:1]};
               next_s.rx_bit = s.rx_bit + 3'h1;
               if (s.rx_bit == 3'(nbits - 4'h1))
                  next_s.rx_st = s.tx_line_control.par_en ? uafs_pkg::RX_PAR : uafs_pkg::RX_STOP;
            end
         end
         uafs_pkg::RX_PAR:
         begin
            if (oversample_pulse && next_s.rx_tick == osr + 5'h1)
            begin
               next_s.rx_tick = 5'h1;
               next_s.rx_perr = (vote != par_of(rx_data, nbits, s.tx_line_control));
               next_s.rx_st = uafs_pkg::RX_STOP;
            end
         end
         uafs_pkg::RX_STOP:
         begin
            if (oversample_pulse && next_s.rx_tick == osr + 5'h1)
            begin
               if (vote)
               begin
                  do_store = 1'b1;
                  st_perr = s.tx_line_control.par_en && s.rx_perr;
                  next_s.rx_st = uafs_pkg::RX_IDLE;
               end
               else
                  next_s.rx_st = uafs_pkg::RX_BRK;
            end
         end
         uafs_pkg::RX_BRK:
         begin
            if (rx_in)
            begin
               do_store = 1'b1;
               st_ferr = 1'b1;
               st_perr = s.tx_line_control.par_en && s.rx_perr;
               next_s.rx_st = uafs_pkg::RX_IDLE;
            end
            else if (s.low_cnt > frame_p)
            begin
               do_store = 1'b1;
               st_ferr = 1'b1;
               st_brk = 1'b1;
               next_s.rx_st = uafs_pkg::RX_WAIT;
            end
         end
         uafs_pkg::RX_WAIT:
         begin
            if (rx_in)
               next_s.rx_st = uafs_pkg::RX_IDLE;
         end
         default: next_s.rx_st = uafs_pkg::RX_IDLE;
      endcase
      if (next_s.rx_st == uafs_pkg::RX_IDLE)
         next_s.rx_perr = 1'b0;

      // Store a finished character, or drop it on overrun
      if (do_store)
      begin
         if (rx_full)
            next_s.ovr_pend = 1'b1;
         else
         begin
            rx_push = 1'b1;
            rx_entry.ovr = s.ovr_pend;
            rx_entry.brk = st_brk;
            rx_entry.perr = st_perr;
            rx_entry.ferr = st_ferr;
            rx_entry.data = st_brk ? 8'h00 : rx_data;
            next_s.ovr_pend = 1'b0;
         end
         if (s.ctrl.sw_fc_en && !st_brk && rx_data == s.xoff_char)
            next_s.xoff_held = 1'b1;
         else if (s.ctrl.sw_fc_en && !st_brk && rx_data == s.xon_char)
            next_s.xoff_held = 1'b0;
      end
      if (!s.ctrl.sw_fc_en)
         next_s.xoff_held = 1'b0;

      // Request-to-send drops at the watermark
      next_s.rts_n = s.ctrl.rts_en && (rx_count >= RCW'(RX_WATERMARK));
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         s <= RESET_ST;
      else if (ce)
         s <= next_s;
   end
endmodule

/* File: testbench/uafs_core_monitor.sv */
/* Port checker of the serial core.
   Assumes ce high and at least one clock per oversampling pulse. */
module uafs_core_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic rx_in,
   input wire logic cts_n,
   input wire logic tx_out,
   input wire logic rts_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Checks
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic fr;
   assign fr = rd && ce && addr == uafs_pkg::FLAG_OFS;
   a_busy_or_empty: assert property (fr |=> rdata[3] || rdata[7])
      else $error("busy low with tx data");
   a_rx_flag_pair: assert property (fr |=> !(rdata[4] && rdata[6]))
      else $error("rx empty and full");
   a_tx_flag_pair: assert property (fr |=> !(rdata[7] && rdata[5]))
      else $error("tx empty and full");
   a_cts_flag: assert property (fr |=> rdata[0] == !$past(cts_n))
      else $error("cts flag wrong");
   a_entry_width: assert property (rd && ce && addr == uafs_pkg::DATA_OFS |=> rdata[31:12] == 0)
      else $error("rx entry too wide");
   a_break_drive: assert property (wr && ce && addr == uafs_pkg::LINE_OFS && wdata[0] |-> ##[1:3] !tx_out)
      else $error("break not driven");
   a_start_length: assert property ($fell(tx_out) |=> !tx_out [*6])
      else $error("low bit too short");
   a_busy_after_write: assert property ((wr && ce && addr == uafs_pkg::DATA_OFS ##2 fr) |=> rdata[3])
      else $error("busy not set");
endmodule
bind uafs_core uafs_core_monitor mon (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .rx_in(rx_in), .cts_n(cts_n), .tx_out(tx_out), .rts_n(rts_n));

/* File: testbench/uafs_far_end.sv */
/* Far-end serial transceiver: drives the receive line, decodes the transmit line.
   Assumes 16 clocks per bit and 8 data bits. */
module uafs_far_end (
   input wire logic clk,
   input wire logic tx_line,
   output logic line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line = 1'b1;
   // ****
   // Frame tasks
   // ****
   task automatic send(input logic [11:0] f, input int n, input int w = 16);
      for (int i = 0; i < n; i++)
      begin
         line <= f[i];
         repeat (w) @(posedge clk);
      end
      line <= 1'b1;
   endtask
   task automatic take(output logic [7:0] d);
      @(negedge tx_line);
      repeat (8) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (16) @(posedge clk);
         d[i] = tx_line;
      end
   endtask
endmodule

/* File: testbench/test_uart_fifo_serial_core.sv */
/* Self-checking bench of the serial core with its far end.
   Assumes divisor 1, fraction 0: 16 clocks per bit. */
module test_uart_fifo_serial_core;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic rx_in;
   logic tx_out;
   logic ce = 1'b1;
   logic cts_n = 1'b0;
   logic rts_n;
   logic [7:0] d;
   int errors = 0;
   int samples_checked = 0;
   always #50 clk = ~clk;
   uafs_core dut (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .rx_in(rx_in), .cts_n(cts_n), .tx_out(tx_out), .rts_n(rts_n));
   uafs_far_end far (.clk(clk), .tx_line(tx_out), .line(rx_in));
   // ****
   // Tasks
   // ****
   task automatic compare(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 compare("reg", e, rdata & m);
   endtask
   task automatic rx_case(input logic [11:0] f, input int n, input logic [31:0] e,
                          input int w = 16);
      far.send(f, n, w);
      repeat (4) @(posedge clk);
      rd_chk(8'h00, 32'hFFFFFFFF, e);
   endtask
   task automatic close_out;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #1000000;
      errors++;
      close_out;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd_chk(8'h04, 32'hFFFFFFFF, 32'h91);
      wr_reg(8'h10, 32'h1);
      wr_reg(8'h08, 32'h70);
      wr_reg(8'h00, 32'h5A);
      rd_chk(8'h04, 32'h88, 32'h08);
      wr_reg(8'h0C, 32'h0D);
      far.take(d);
      compare("tx_byte", 32'h5A, {24'h0, d});
      repeat (40) @(posedge clk);
      rd_chk(8'h04, 32'h88, 32'h80);
      rx_case({1'b1, 8'h3C, 1'b0}, 10, 32'h03C);
      rx_case({1'b0, 8'h3C, 1'b0}, 10, 32'h13C);
      wr_reg(8'h08, 32'h76);
      rx_case({2'b10, 8'h01, 1'b0}, 11, 32'h201);
      rx_case({2'b11, 8'h01, 1'b0}, 11, 32'h001);
      wr_reg(8'h08, 32'h72);
      rx_case({2'b10, 8'h01, 1'b0}, 11, 32'h001);
      wr_reg(8'h08, 32'hF2);
      rx_case({2'b11, 8'h02, 1'b0}, 11, 32'h002);
      wr_reg(8'h08, 32'h70);
      rx_case(12'h000, 12, 32'h500);
      far.send(12'h000, 1, 3);
      repeat (170) @(posedge clk);
      rd_chk(8'h04, 32'h10, 32'h10);
      wr_reg(8'h08, 32'h30);
      far.send({1'b1, 8'h21, 1'b0}, 10);
      @(posedge clk);
      far.send({1'b1, 8'h22, 1'b0}, 10);
      rd_chk(8'h04, 32'h04, 32'h04);
      rd_chk(8'h00, 32'hFFFFFFFF, 32'h021);
      rx_case({1'b1, 8'h23, 1'b0}, 10, 32'h823);
      wr_reg(8'h0C, 32'h0F);
      wr_reg(8'h08, 32'h60);
      rx_case({1'b1, 7'h55, 1'b0}, 9, 32'h055, 8);
      wr_reg(8'h08, 32'h71);
      repeat (6) @(posedge clk);
      compare("tx_out", 32'h0, {31'h0, tx_out});
      wr_reg(8'h08, 32'h70);
      cts_n <= 1'b1;
      wr_reg(8'h0C, 32'h2D);
      wr_reg(8'h00, 32'h00);
      rd_chk(8'h04, 32'h81, 32'h00);
      compare("rts_n", 32'h0, {31'h0, rts_n});
      ce <= 1'b0;
      wr_reg(8'h14, 32'h3F);
      ce <= 1'b1;
      rd_chk(8'h14, 32'h3F, 32'h00);
      close_out;
   end
endmodule
